// >>> logic/sdo_deserializer.sv
// receive side of an embedded-clock 10-bit serial link with apb registers
`include "sdo_params.svh"
module sdo_deserializer
	import sdo_pkg::*;
#(
	parameter int DATA_BITS = `SDO_DATA_BITS,
	parameter int LOSS_COUNT = `SDO_LOSS_COUNT,
	parameter int ACQ_COUNT = `SDO_ACQ_COUNT
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	output logic irq, // level interrupt
	input wire logic serial_in_pos, // serial stream, true side
	input wire logic serial_in_neg, // serial stream, inverted side
	input wire logic local_reference_clock, // reference clock, bit rate
	input wire logic strobe_edge_sel, // high: rising strobe edge
	input wire logic power_down_n, // low: power down
	input wire logic output_enable, // low: data and clock float, lock indicator floats only if locked
	output logic [DATA_BITS-1:0] parallel_data_out, // recovered word
	output logic parallel_data_oe, // data outputs driven
	output logic recovered_clock, // word rate clock
	output logic recovered_clock_oe, // recovered clock driven
	output logic lock_n, // lock indicator, active low
	output logic lock_n_oe // lock indicator driven
);
	localparam int FB = DATA_BITS + (`SDO_FRAME_BITS - `SDO_DATA_BITS);
	localparam logic [3:0] LAST_BIT = 4'(FB - 1);
	localparam logic [3:0] HALF_BIT = 4'(FB / 2);
	localparam logic [2:0] LOSS_LAST = 3'(LOSS_COUNT - 1);
	localparam logic [2:0] ACQ_LAST = 3'(ACQ_COUNT - 1);
	if (DATA_BITS != `SDO_DATA_BITS || LOSS_COUNT < 1 || LOSS_COUNT > 7 || ACQ_COUNT < 1 || ACQ_COUNT > 7)
		$error("sdo_deserializer: unsupported parameter values");

	// window holds a whole frame, oldest bit in the lsb: leading one, trailing zero
	function automatic logic frame_ok(input logic [FB-1:0] w, input logic bad);
		frame_ok = w[0] && !w[FB-1] && !bad;
	endfunction
	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	logic [`SDO_SYNC_BITS-1:0] raw, s1_q, s2_q;
	logic ref_prev_q, oe_prev_q;
	logic pos_s, neg_s, ref_s, sel_s, pdn_s, oe_s, ref_rise, oe_fell;

	assign raw = {serial_in_pos, serial_in_neg, local_reference_clock, strobe_edge_sel, power_down_n, output_enable};
	assign {pos_s, neg_s, ref_s, sel_s, pdn_s, oe_s} = s2_q;
	assign ref_rise = ref_s && !ref_prev_q;
	assign oe_fell = oe_prev_q && !oe_s;

	// two flops before any logic, then edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '0;
			s2_q <= '0;
			ref_prev_q <= 1'b0;
			oe_prev_q <= 1'b0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			ref_prev_q <= ref_s;
			oe_prev_q <= oe_s;
		end
	end
	// ---------------------------------------------------------------
	// frame recovery and lock tracking
	// ---------------------------------------------------------------
	sdo_rx_state_t st_q, st_d;
	logic [FB-1:0] win_q, win_d;
	logic [3:0] bit_q, bit_d;
	logic [2:0] cnt_q, cnt_d;
	logic bad_q, bad_d;
	logic [DATA_BITS-1:0] word_q, word_d;
	logic word_ev, gained_ev, lost_ev, force_unlock;
	logic [FB-1:0] nwin;
	logic nbad;

	// shift serial bits on each reference rise and judge whole frames
	always_comb begin
		st_d = st_q;
		win_d = win_q;
		bit_d = bit_q;
		cnt_d = cnt_q;
		bad_d = bad_q;
		word_d = word_q;
		word_ev = 1'b0;
		gained_ev = 1'b0;
		lost_ev = 1'b0;
		nwin = {pos_s, win_q[FB-1:1]}; // oldest bit falls to the lsb, d0 lands in word bit 0
		nbad = bad_q || (pos_s == neg_s); // no differential activity
		if (!pdn_s) begin
			st_d = SDO_ST_OFF;
			bit_d = '0;
			cnt_d = '0;
			bad_d = 1'b0;
			lost_ev = (st_q == SDO_ST_LOCK);
		end else if (force_unlock) begin
			st_d = SDO_ST_HUNT;
			cnt_d = '0;
			lost_ev = (st_q == SDO_ST_LOCK);
		end else if (ref_rise) begin
			win_d = nwin;
			bit_d = (bit_q == LAST_BIT) ? 4'h0 : bit_q + 4'h1;
			bad_d = (bit_q == LAST_BIT) ? 1'b0 : nbad;
			case (st_q)
				SDO_ST_OFF, SDO_ST_HUNT: begin
					// random lock: align on the first window that looks framed
					st_d = SDO_ST_HUNT;
					if (frame_ok(nwin, pos_s == neg_s)) begin
						st_d = SDO_ST_ACQ;
						bit_d = '0;
						bad_d = 1'b0;
						cnt_d = '0;
					end
				end
				SDO_ST_ACQ: begin
					if (bit_q == LAST_BIT) begin
						if (!frame_ok(nwin, nbad)) begin
							st_d = SDO_ST_HUNT;
						end else if (cnt_q == ACQ_LAST) begin
							st_d = SDO_ST_LOCK;
							cnt_d = '0;
							gained_ev = 1'b1;
						end else begin
							cnt_d = cnt_q + 3'h1;
						end
					end
				end
				SDO_ST_LOCK: begin
					if (bit_q == LAST_BIT) begin
						if (frame_ok(nwin, nbad)) begin
							cnt_d = '0;
							word_d = nwin[FB-2:1];
							word_ev = 1'b1;
						end else if (cnt_q == LOSS_LAST) begin
							st_d = SDO_ST_HUNT;
							cnt_d = '0;
							lost_ev = 1'b1;
						end else begin
							cnt_d = cnt_q + 3'h1;
						end
					end
				end
				default: st_d = SDO_ST_OFF;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= SDO_ST_OFF;
			win_q <= '0;
			bit_q <= '0;
			cnt_q <= '0;
			bad_q <= 1'b0;
			word_q <= '0;
		end else begin
			st_q <= st_d;
			win_q <= win_d;
			bit_q <= bit_d;
			cnt_q <= cnt_d;
			bad_q <= bad_d;
			word_q <= word_d;
		end
	end
	// ---------------------------------------------------------------
	// output pins and enables
	// ---------------------------------------------------------------
	logic locked, pend_q, pend_d, hiz_q, hiz_d;
	logic rclk_d, doe_d, lock_n_d, loe_d;
	assign locked = (st_q == SDO_ST_LOCK);

	// clock low half after a word update, inverted for falling strobe
	always_comb begin
		rclk_d = (bit_d >= HALF_BIT) ^ !sel_s;
		doe_d = pdn_s && oe_s && locked;
		lock_n_d = !locked;
		pend_d = pend_q;
		hiz_d = hiz_q;
		if (!pdn_s || oe_s) begin
			pend_d = 1'b0;
			hiz_d = 1'b0;
		end else if (oe_fell) begin
			pend_d = locked;
		end else if (pend_q && ref_rise) begin
			pend_d = 1'b0;
			hiz_d = 1'b1;
		end
		loe_d = pdn_s && !hiz_d;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			parallel_data_out <= '0;
			recovered_clock <= 1'b0;
			parallel_data_oe <= 1'b0;
			recovered_clock_oe <= 1'b0;
			lock_n <= 1'b1;
			lock_n_oe <= 1'b0;
			pend_q <= 1'b0;
			hiz_q <= 1'b0;
		end else begin
			parallel_data_out <= word_d;
			recovered_clock <= rclk_d;
			parallel_data_oe <= doe_d;
			recovered_clock_oe <= doe_d;
			lock_n <= lock_n_d;
			lock_n_oe <= loe_d;
			pend_q <= pend_d;
			hiz_q <= hiz_d;
		end
	end
	// ---------------------------------------------------------------
	// apb registers and interrupt
	// ---------------------------------------------------------------
	logic ctrl_q, ctrl_d;
	logic [`SDO_INT_BITS-1:0] ist_q, ist_d, imask_q, imask_d, icap_q, icap_d, iset;
	logic [31:0] rd_q, rd_d, rdmux;
	logic setup, access, mapped, wr, rd_int;

	assign force_unlock = ctrl_q;
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign mapped = paddr == `SDO_ADDR_CTRL || paddr == `SDO_ADDR_STATUS || paddr == `SDO_ADDR_INT_STATUS
		|| paddr == `SDO_ADDR_INT_MASK || paddr == `SDO_ADDR_WORD;
	assign pready = access;
	assign pslverr = access && !mapped;
	assign prdata = rd_q;
	assign irq = |(ist_q & imask_q);
	assign iset = {word_ev, lost_ev, gained_ev};
	assign wr = access && pwrite;
	assign rd_int = access && !pwrite && paddr == `SDO_ADDR_INT_STATUS;

	// read data captured in setup; read clears only captured bits, set wins
	always_comb begin
		rdmux = 32'h0000_0000;
		case (paddr)
			`SDO_ADDR_CTRL: rdmux[`SDO_CTRL_FORCE_UNLOCK] = ctrl_q;
			`SDO_ADDR_STATUS: rdmux[`SDO_ST_LOCK_HIZ:`SDO_ST_LOCKED] = {hiz_q, oe_s, pdn_s, locked};
			`SDO_ADDR_INT_STATUS: rdmux[`SDO_INT_BITS-1:0] = ist_q;
			`SDO_ADDR_INT_MASK: rdmux[`SDO_INT_BITS-1:0] = imask_q;
			`SDO_ADDR_WORD: rdmux[DATA_BITS-1:0] = word_q;
			default: rdmux = 32'h0000_0000;
		endcase
		rd_d = setup ? rdmux : rd_q;
		icap_d = setup ? ist_q : icap_q;
		ctrl_d = (wr && paddr == `SDO_ADDR_CTRL) ? pwdata[`SDO_CTRL_FORCE_UNLOCK] : ctrl_q;
		imask_d = (wr && paddr == `SDO_ADDR_INT_MASK) ? pwdata[`SDO_INT_BITS-1:0] : imask_q;
		ist_d = (rd_int ? (ist_q & ~icap_q) : ist_q) | iset;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 1'b0;
			imask_q <= '0;
			ist_q <= '0;
			icap_q <= '0;
			rd_q <= 32'h0000_0000;
		end else begin
			ctrl_q <= ctrl_d;
			imask_q <= imask_d;
			ist_q <= ist_d;
			icap_q <= icap_d;
			rd_q <= rd_d;
		end
	end
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_strobe_edge;
		@(posedge pclk) disable iff (!presetn)
		(parallel_data_out != $past(parallel_data_out)) |-> recovered_clock == !$past(sel_s);
	endproperty
	a_strobe_edge: assert property (p_strobe_edge) else $error("data changed on wrong strobe phase");
	property p_power_down;
		@(posedge pclk) disable iff (!presetn)
		!pdn_s |=> !parallel_data_oe && !recovered_clock_oe && !lock_n_oe && st_q == SDO_ST_OFF;
	endproperty
	a_power_down: assert property (p_power_down) else $error("outputs driven in power down");
	property p_lock_ind;
		@(posedge pclk) disable iff (!presetn)
		##1 lock_n == ($past(st_q) != SDO_ST_LOCK);
	endproperty
	a_lock_ind: assert property (p_lock_ind) else $error("lock indicator disagrees with lock");
	property p_oe_float;
		@(posedge pclk) disable iff (!presetn)
		!oe_s |=> !parallel_data_oe && !recovered_clock_oe;
	endproperty
	a_oe_float: assert property (p_oe_float) else $error("outputs driven with enable low");
	property p_lock_float;
		@(posedge pclk) disable iff (!presetn)
		(oe_fell && locked && pdn_s) ##1 (!oe_s && pdn_s)[*8] ##[0:8] (!oe_s && pdn_s && ref_rise) |=> ##1 !lock_n_oe;
	endproperty
	a_lock_float: assert property (p_lock_float) else $error("lock indicator not floated");
	property p_unlock_drive;
		@(posedge pclk) disable iff (!presetn)
		(!oe_s && pdn_s && !locked && !pend_q && !hiz_q) |=> lock_n_oe && lock_n;
	endproperty
	a_unlock_drive: assert property (p_unlock_drive) else $error("unlocked indicator not driven high");
	property p_word_boundary;
		@(posedge pclk) disable iff (!presetn)
		(word_q != $past(word_q)) |-> $past(bit_q) == LAST_BIT && $past(ref_rise);
	endproperty
	a_word_boundary: assert property (p_word_boundary) else $error("word updated off frame boundary");
	property p_loss_count;
		@(posedge pclk) disable iff (!presetn)
		(st_q == SDO_ST_HUNT && $past(st_q) == SDO_ST_LOCK && $past(pdn_s) && !$past(ctrl_q))
			|-> $past(cnt_q) == LOSS_LAST;
	endproperty
	a_loss_count: assert property (p_loss_count) else $error("lock lost before four bad words");
	property p_data_float;
		@(posedge pclk) disable iff (!presetn)
		!locked |=> !parallel_data_oe;
	endproperty
	a_data_float: assert property (p_data_float) else $error("data driven while unlocked");
endmodule

// >>> logic/sdo_params.svh
// constants for the serial deserializer output control block
`ifndef SDO_PARAMS_SVH
`define SDO_PARAMS_SVH
// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define SDO_ADDR_CTRL 12'h000
`define SDO_ADDR_STATUS 12'h004
`define SDO_ADDR_INT_STATUS 12'h008
`define SDO_ADDR_INT_MASK 12'h00c
`define SDO_ADDR_WORD 12'h010
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SDO_CTRL_FORCE_UNLOCK 0
`define SDO_ST_LOCKED 0
`define SDO_ST_POWERED 1
`define SDO_ST_ENABLED 2
`define SDO_ST_LOCK_HIZ 3
`define SDO_INT_GAINED 0
`define SDO_INT_LOST 1
`define SDO_INT_WORD 2
`define SDO_INT_BITS 3
// ---------------------------------------------------------------
// framing and lock counts
// ---------------------------------------------------------------
`define SDO_DATA_BITS 10
`define SDO_FRAME_BITS 12
`define SDO_LOSS_COUNT 4
`define SDO_ACQ_COUNT 4
`define SDO_SYNC_BITS 6
`endif

// >>> logic/sdo_pkg.sv
// types shared by the serial deserializer output control block
package sdo_pkg;
	typedef enum logic [1:0] {
		SDO_ST_OFF = 2'b00,
		SDO_ST_HUNT = 2'b01,
		SDO_ST_ACQ = 2'b10,
		SDO_ST_LOCK = 2'b11
	} sdo_rx_state_t;
endpackage

// >>> test/sdo_ser_model.sv
// serializer model that frames words onto the serial pair
module sdo_ser_model (
	input wire logic ref_clk, // bit clock from the bench
	input wire logic [9:0] next_word, // word for the next frame
	input wire logic bad, // frame sent with no activity
	output logic pos, // true side
	output logic neg, // inverted side
	output logic [9:0] done_word, // last fully sent word
	output int nframe // frames started so far
);
	timeunit 1ns;
	timeprecision 1ps;
	int bit_i = 0;
	logic [11:0] frame = 12'h000;
	logic bad_q = 1'b0;
	initial begin
		pos = 1'b0;
		neg = 1'b0;
		done_word = 10'h000;
		nframe = 0;
	end
	// one bit per period, moved on the far edge from the receiver's sample
	always @(negedge ref_clk) begin
		if (bit_i == 0) begin
			frame = {1'b0, next_word, 1'b1};
			bad_q = bad;
			nframe++;
		end
		pos <= frame[bit_i];
		neg <= bad_q ? frame[bit_i] : ~frame[bit_i];
		if (bit_i == 11) done_word <= frame[10:1];
		bit_i = (bit_i + 1) % 12;
	end
endmodule

// >>> test/tb_top.sv
// self-checking bench for the serial deserializer output control block
`include "sdo_params.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq, pos, neg, ref_clk = 1'b0, sel = 1'b1, pd_n = 1'b0, oe_in = 1'b0, bad = 1'b0;
	logic [9:0] dout, nxt = 10'h000, done_w;
	logic dout_oe, rclk, rclk_oe, lock_n, lock_n_oe;
	logic [7:0] lf = 8'h62;
	logic [4:0][9:0] hist = '0; // last five words handed to the serializer
	logic [9:0] w;
	logic resend = 1'b0;
	int rs_i = 0;
	int n_fail = 0, cmp_count = 0, nframe, k;
	// ---------------------------------------------------------------
	// clocks, parts and random words
	// ---------------------------------------------------------------
	always #5 pclk = ~pclk;
	always #62.5 ref_clk = ~ref_clk;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// new word for each frame, all ones now and then; replays the history once asked
	always @(nframe) begin
		@(posedge pclk);
		lf <= lfsr(lf);
		w = (nframe % 7 == 0) ? 10'h3ff : {lf[1:0], lf};
		if (resend && rs_i < 5) begin
			w = hist[rs_i];
			rs_i++;
		end else if (!resend) begin
			hist <= {w, hist[4:1]};
		end
		nxt <= w;
	end
	sdo_deserializer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.serial_in_pos(pos), .serial_in_neg(neg), .local_reference_clock(ref_clk), .strobe_edge_sel(sel),
		.power_down_n(pd_n), .output_enable(oe_in), .parallel_data_out(dout), .parallel_data_oe(dout_oe),
		.recovered_clock(rclk), .recovered_clock_oe(rclk_oe), .lock_n(lock_n), .lock_n_oe(lock_n_oe));
	sdo_ser_model u_ser (.ref_clk(ref_clk), .next_word(nxt), .bad(bad), .pos(pos), .neg(neg),
		.done_word(done_w), .nframe(nframe));
	// ---------------------------------------------------------------
	// checking and bus tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic expire(input logic ok, input string nm);
		if (ok !== 1'b1) begin
			n_fail++;
			$display("wrong value %s expected event seen timeout", nm);
			tally_and_finish();
		end
	endtask
	function automatic logic pick(input int w);
		case (w)
			0: return lock_n;
			1: return rclk;
			2: return lock_n_oe;
			default: return dout_oe;
		endcase
	endfunction
	// bounded wait for an output level, sampled between edges
	task automatic wait_sig(input int w, input logic v, input int lim);
		for (int i = 0; i < lim && pick(w) !== v; i++) @(negedge pclk);
		expire(pick(w) === v, "level wait");
	endtask
	task automatic wait_fr(input int n);
		int s;
		s = nframe + n;
		for (int i = 0; i < n * 200 && nframe < s; i++) @(negedge pclk);
		expire(nframe >= s, "frame wait");
	endtask
	// one apb transfer, held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		expire(pready === 1'b1, "pready");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk("lock_n", lock_n, 1);
		chk("oe", {lock_n_oe, dout_oe, rclk_oe}, 0);
		apb(0, `SDO_ADDR_STATUS, 0);
		chk("status", rd & 32'h7, 0);
		apb(1, `SDO_ADDR_CTRL, 1);
		apb(0, `SDO_ADDR_CTRL, 0);
		chk("ctrl", rd, 1);
		apb(1, `SDO_ADDR_CTRL, 0);
		apb(0, 12'h020, 0);
		chk("slverr", err, 1);
		apb(1, `SDO_ADDR_INT_MASK, 32'h3);
		apb(0, `SDO_ADDR_INT_MASK, 0);
		chk("mask", rd, 3);
		// power up, then lock to random words
		pd_n <= 1'b1;
		oe_in <= 1'b1;
		wait_sig(0, 0, 3000);
		chk("irq", irq, 1);
		apb(0, `SDO_ADDR_INT_STATUS, 0);
		chk("gained", rd & 32'h3, 1);
		apb(0, `SDO_ADDR_INT_STATUS, 0);
		chk("cleared", rd & 32'h3, 0);
		@(negedge pclk);
		chk("irq", irq, 0);
		// word stands at the selected strobe edge
		for (k = 0; k < 8; k++) begin
			@(posedge pclk);
			sel <= k[2];
			wait_fr(1);
			wait_sig(1, !sel, 200);
			wait_sig(1, sel, 200);
			chk("word", dout, done_w);
			chk("data_oe", {dout_oe, rclk_oe}, 3);
			apb(0, `SDO_ADDR_WORD, 0);
			chk("word_reg", rd, done_w);
		end
		// forced unlock from software, then relock
		apb(1, `SDO_ADDR_CTRL, 1);
		wait_sig(0, 1, 10);
		apb(0, `SDO_ADDR_INT_STATUS, 0);
		chk("forced_loss", rd & 32'h2, 2);
		apb(1, `SDO_ADDR_CTRL, 0);
		wait_sig(0, 0, 3000);
		apb(0, `SDO_ADDR_INT_STATUS, 0);
		chk("regained", rd & 32'h3, 1);
		// enable low while locked
		@(posedge pclk);
		oe_in <= 1'b0;
		@(negedge pclk);
		chk("lock_oe", lock_n_oe, 1);
		wait_sig(3, 0, 10);
		chk("rclk_oe", rclk_oe, 0);
		wait_sig(2, 0, 40);
		apb(0, `SDO_ADDR_STATUS, 0);
		chk("status_float", rd & 32'hf, 32'hb);
		@(posedge pclk);
		oe_in <= 1'b1;
		wait_sig(2, 1, 40);
		// lock held over three bad words, lost on the fourth
		wait_fr(1);
		@(posedge pclk);
		bad <= 1'b1;
		wait_fr(4);
		repeat (20) @(negedge pclk);
		chk("lock_n", lock_n, 0);
		wait_fr(1);
		wait_sig(0, 1, 60);
		chk("irq", irq, 1);
		wait_sig(3, 0, 10);
		// enable low while unlocked keeps the indicator driven
		@(posedge pclk);
		oe_in <= 1'b0;
		bad <= 1'b0;
		wait_sig(0, 0, 3000);
		chk("lock_oe", lock_n_oe, 1);
		chk("data_oe", dout_oe, 0);
		// far end replays the last five words handed out before relock, once relocked
		resend <= 1'b1;
		wait_fr(7);
		apb(0, `SDO_ADDR_WORD, 0);
		chk("resent", rd, hist[4]);
		@(posedge pclk);
		oe_in <= 1'b1;
		wait_sig(3, 1, 20);
		// power down floats everything
		@(posedge pclk);
		pd_n <= 1'b0;
		wait_sig(2, 0, 10);
		chk("oe", {dout_oe, rclk_oe}, 0);
		apb(0, `SDO_ADDR_STATUS, 0);
		chk("powered", rd[1], 0);
		tally_and_finish();
	end
	// cuts a hung run short
	initial begin
		#800000;
		expire(1'b0, "run");
	end
endmodule
